// File: bridge_window_upper_regs.sv
// bridge_window_upper_regs: slice of a type 1 bridge header holding the
// prefetchable limit, the upper window halves, capability pointer,
// option rom base and interrupt routing scratch, plus window decode.
// assumes a synchronous avalon-mm master on sys_clk_i and addresses
// presented to the decoders synchronous to the same clock.
//
// Our own choice: the Avalon-MM slave port.

`timescale 1ns/100ps

`include "bridge_window_upper_regs.svh"

module bridge_window_upper_regs
    import bridge_window_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic [1:0] avs_response_o,
    output logic avs_waitrequest_o,
    input wire logic [63:0] pf_addr_i,
    input wire logic [31:0] io_addr_i,
    output logic pf_hit_o,
    output logic io_hit_o,
    output pf_window_t pf_window_o,
    output io_window_t io_window_o
);

    bus_phase_t phase;
    logic [7:0] idx;
    logic take_write;
    logic take_read;
    logic [31:0] next_readdata;
    logic next_error;

    logic prefetch_wide_capable;
    logic [11:0] prefetch_base_low;
    logic [11:0] prefetch_limit_low;
    logic [31:0] prefetch_base_upper;
    logic [31:0] prefetch_limit_upper;
    logic io_wide_capable;
    logic [3:0] io_base_low;
    logic [3:0] io_limit_low;
    logic [15:0] io_base_upper;
    logic [15:0] io_limit_upper;
    logic [7:0] capability_list_pointer;
    logic [7:0] interrupt_routing_scratch;
    logic unlock;

    logic [31:0] pf_base_up_eff;
    logic [31:0] pf_limit_up_eff;
    logic [15:0] io_base_up_eff;
    logic [15:0] io_limit_up_eff;
    pf_window_t next_pf_window;
    io_window_t next_io_window;

    // merge a write with the stored word under the byte enables
    function automatic logic [31:0] merge_be(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign idx = avs_address_i[9:2];

    // one wait state: the request is seen, then answered on the next edge
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase <= PH_IDLE;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        phase <= PH_ANSWER;
                    end
                end
                PH_ANSWER: begin
                    phase <= PH_IDLE;
                end
                default: begin
                    phase <= PH_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest_o = (phase != PH_ANSWER);
    assign take_write = (phase == PH_ANSWER) && avs_write_i;
    assign take_read = (phase == PH_IDLE) && avs_read_i;

    // narrow-mode upper halves act as zero for reads and decode
    assign pf_base_up_eff =
        prefetch_wide_capable ? prefetch_base_upper : 32'h0;
    assign pf_limit_up_eff =
        prefetch_wide_capable ? prefetch_limit_upper : 32'h0;
    assign io_base_up_eff =
        io_wide_capable ? io_base_upper : 16'h0;
    assign io_limit_up_eff =
        io_wide_capable ? io_limit_upper : 16'h0;

    // read mux; data is captured before the answer edge
    always_comb begin
        next_readdata = 32'h0;
        next_error = 1'b0;
        case (idx)
            `IDX_IO_BASE_LOW: begin
                next_readdata[`IO_FIELD_HI:`IO_FIELD_LO] = io_base_low;
                next_readdata[`WIDE_CAP_BIT] = io_wide_capable;
            end
            `IDX_IO_LIMIT_LOW: begin
                next_readdata[`IO_FIELD_HI:`IO_FIELD_LO] = io_limit_low;
                next_readdata[`WIDE_CAP_BIT] = io_wide_capable;
            end
            `IDX_PF_BASE_LOW: begin
                next_readdata[`PF_FIELD_HI:`PF_FIELD_LO] =
                    prefetch_base_low;
                next_readdata[`WIDE_CAP_BIT] =
                    prefetch_wide_capable;
            end
            `IDX_PF_LIMIT_LOW: begin
                next_readdata[`PF_FIELD_HI:`PF_FIELD_LO] =
                    prefetch_limit_low;
                next_readdata[`WIDE_CAP_BIT] =
                    prefetch_wide_capable;
            end
            `IDX_PF_BASE_UPPER: begin
                next_readdata = pf_base_up_eff;
            end
            `IDX_PF_LIMIT_UPPER: begin
                next_readdata = pf_limit_up_eff;
            end
            `IDX_IO_BASE_UPPER: begin
                next_readdata[15:0] = io_base_up_eff;
            end
            `IDX_IO_LIMIT_UPPER: begin
                next_readdata[15:0] = io_limit_up_eff;
            end
            `IDX_CAP_PTR: begin
                next_readdata[7:0] = capability_list_pointer;
            end
            `IDX_OPTION_ROM: begin
                next_readdata = 32'h0;
            end
            `IDX_INTR_SCRATCH: begin
                next_readdata[7:0] = interrupt_routing_scratch;
            end
            `IDX_CFG_LOCK: begin
                next_readdata[`UNLOCK_BIT] = unlock;
            end
            default: begin
                next_error = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0;
            avs_response_o <= `RESP_OKAY;
        end else if (phase == PH_IDLE && (avs_read_i || avs_write_i)) begin
            avs_readdata_o <= take_read ? next_readdata : 32'h0;
            avs_response_o <= next_error ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    // unlock gates the hardware-initialised fields
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unlock <= `RST_UNLOCK;
        end else if (take_write && idx == `IDX_CFG_LOCK &&
                     avs_byteenable_i[0]) begin
            unlock <= avs_writedata_i[`UNLOCK_BIT];
        end
    end

    // prefetchable base low word: capability bit locked, base field free
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prefetch_wide_capable <= `RST_PF_WIDE;
            prefetch_base_low <= `RST_PF_BASE_LOW;
        end else if (take_write && idx == `IDX_PF_BASE_LOW) begin
            if (avs_byteenable_i[0] && unlock) begin
                prefetch_wide_capable <=
                    avs_writedata_i[`WIDE_CAP_BIT];
            end
            if (avs_byteenable_i[0]) begin
                prefetch_base_low[3:0] <= avs_writedata_i[7:4];
            end
            if (avs_byteenable_i[1]) begin
                prefetch_base_low[11:4] <= avs_writedata_i[15:8];
            end
        end
    end

    // limit bit 0 is not stored: it mirrors the capability bit
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prefetch_limit_low <= `RST_PF_LIMIT_LOW;
        end else if (take_write && idx == `IDX_PF_LIMIT_LOW) begin
            if (avs_byteenable_i[0]) begin
                prefetch_limit_low[3:0] <= avs_writedata_i[7:4];
            end
            if (avs_byteenable_i[1]) begin
                prefetch_limit_low[11:4] <= avs_writedata_i[15:8];
            end
        end
    end

    // stored upper values survive a narrow spell but are not visible
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prefetch_base_upper <= `RST_PF_BASE_UPPER;
            prefetch_limit_upper <= `RST_PF_LIMIT_UPPER;
        end else if (take_write && prefetch_wide_capable) begin
            if (idx == `IDX_PF_BASE_UPPER) begin
                prefetch_base_upper <= merge_be(prefetch_base_upper,
                    avs_writedata_i, avs_byteenable_i);
            end
            if (idx == `IDX_PF_LIMIT_UPPER) begin
                prefetch_limit_upper <= merge_be(prefetch_limit_upper,
                    avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // io low words: capability bit locked, address nibbles free
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_wide_capable <= `RST_IO_WIDE;
            io_base_low <= `RST_IO_BASE_LOW;
            io_limit_low <= `RST_IO_LIMIT_LOW;
        end else if (take_write && avs_byteenable_i[0]) begin
            if (idx == `IDX_IO_BASE_LOW) begin
                io_base_low <= avs_writedata_i[`IO_FIELD_HI:`IO_FIELD_LO];
                if (unlock) begin
                    io_wide_capable <= avs_writedata_i[`WIDE_CAP_BIT];
                end
            end
            if (idx == `IDX_IO_LIMIT_LOW) begin
                io_limit_low <= avs_writedata_i[`IO_FIELD_HI:`IO_FIELD_LO];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_base_upper <= `RST_IO_BASE_UPPER;
            io_limit_upper <= `RST_IO_LIMIT_UPPER;
        end else if (take_write && io_wide_capable) begin
            if (idx == `IDX_IO_BASE_UPPER) begin
                io_base_upper <= 16'(merge_be({16'h0, io_base_upper},
                    avs_writedata_i, avs_byteenable_i));
            end
            if (idx == `IDX_IO_LIMIT_UPPER) begin
                io_limit_upper <= 16'(merge_be({16'h0, io_limit_upper},
                    avs_writedata_i, avs_byteenable_i));
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            capability_list_pointer <= `RST_CAP_PTR;
        end else if (take_write && idx == `IDX_CAP_PTR && unlock &&
                     avs_byteenable_i[0]) begin
            capability_list_pointer <= avs_writedata_i[7:0];
        end
    end

    // scratch only: nothing below reads it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            interrupt_routing_scratch <= `RST_INTR_SCRATCH;
        end else if (take_write && idx == `IDX_INTR_SCRATCH &&
                     avs_byteenable_i[0]) begin
            interrupt_routing_scratch <= avs_writedata_i[7:0];
        end
    end

    // window bounds; low address bits implied zero for base, ones for limit
    always_comb begin
        next_pf_window.lowest = {pf_base_up_eff, prefetch_base_low,
            `PF_LOW_ZERO};
        next_pf_window.highest = {pf_limit_up_eff, prefetch_limit_low,
            `PF_LOW_ONES};
        next_pf_window.wide = prefetch_wide_capable;
        next_io_window.lowest = {io_base_up_eff, io_base_low,
            `IO_LOW_ZERO};
        next_io_window.highest = {io_limit_up_eff, io_limit_low,
            `IO_LOW_ONES};
        next_io_window.wide = io_wide_capable;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pf_window_o <= '0;
            io_window_o <= '0;
        end else begin
            pf_window_o <= next_pf_window;
            io_window_o <= next_io_window;
        end
    end

    // registered compare: one cycle from address to hit, and a base above
    // the limit simply never hits, which is how software closes a window
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pf_hit_o <= 1'b0;
            io_hit_o <= 1'b0;
        end else begin
            pf_hit_o <= (pf_addr_i >= next_pf_window.lowest) &&
                (pf_addr_i <= next_pf_window.highest);
            io_hit_o <= (io_addr_i >= next_io_window.lowest) &&
                (io_addr_i <= next_io_window.highest);
        end
    end

endmodule

// File: bridge_window_upper_regs.svh
// bridge_window_upper_regs.svh: register indices, field positions, reset
// values and timing counts for the bridge window register slice.
// assumes a 32-bit avalon slave with one aligned word per register index.
`ifndef BRIDGE_WINDOW_UPPER_REGS_SVH
`define BRIDGE_WINDOW_UPPER_REGS_SVH

// register indices; byte address is four times the index
`define IDX_IO_BASE_LOW 8'h1c
`define IDX_IO_LIMIT_LOW 8'h1d
`define IDX_PF_BASE_LOW 8'h24
`define IDX_PF_LIMIT_LOW 8'h26
`define IDX_PF_BASE_UPPER 8'h28
`define IDX_PF_LIMIT_UPPER 8'h2c
`define IDX_IO_BASE_UPPER 8'h30
`define IDX_IO_LIMIT_UPPER 8'h32
`define IDX_CAP_PTR 8'h34
`define IDX_OPTION_ROM 8'h38
`define IDX_INTR_SCRATCH 8'h3c
`define IDX_CFG_LOCK 8'h50

// field positions
`define WIDE_CAP_BIT 0
`define PF_FIELD_HI 15
`define PF_FIELD_LO 4
`define IO_FIELD_HI 7
`define IO_FIELD_LO 4
`define UNLOCK_BIT 0

// reset values
`define RST_PF_WIDE 1'h1
`define RST_PF_BASE_LOW 12'hfff
`define RST_PF_LIMIT_LOW 12'h000
`define RST_PF_BASE_UPPER 32'hffff_ffff
`define RST_PF_LIMIT_UPPER 32'h0000_0000
`define RST_IO_WIDE 1'h1
`define RST_IO_BASE_LOW 4'hf
`define RST_IO_LIMIT_LOW 4'h0
`define RST_IO_BASE_UPPER 16'hffff
`define RST_IO_LIMIT_UPPER 16'h0000
`define RST_CAP_PTR 8'h40
`define RST_INTR_SCRATCH 8'h00
`define RST_UNLOCK 1'h0

// implied low address bits of base and limit
`define PF_LOW_ZERO 20'h0_0000
`define PF_LOW_ONES 20'hf_ffff
`define IO_LOW_ZERO 12'h000
`define IO_LOW_ONES 12'hfff

// avalon answer codes and wait states before the answer
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BUS_WAIT_CYCLES 1

`endif

// File: bridge_window_pkg.sv
// bridge_window_pkg: types shared by the bridge window register slice.
// assumes the constants header is included by every user of these types.
package bridge_window_pkg;

    typedef enum logic {
        PH_IDLE,
        PH_ANSWER
    } bus_phase_t;

    typedef struct packed {
        logic [63:0] lowest;
        logic [63:0] highest;
        logic wide;
    } pf_window_t;

    typedef struct packed {
        logic [31:0] lowest;
        logic [31:0] highest;
        logic wide;
    } io_window_t;

endpackage

// File: bridge_window_upper_regs_properties.sv
// bridge_window_upper_regs_properties: bus and decode checks on the slice.
// assumes one clock domain and the constants header for the index map.
`timescale 1ns/100ps
`include "bridge_window_upper_regs.svh"
module bridge_window_upper_regs_checker
    import bridge_window_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic [1:0] avs_response_o,
    input wire logic avs_waitrequest_o,
    input wire logic [63:0] pf_addr_i,
    input wire logic [31:0] io_addr_i,
    input wire logic pf_hit_o,
    input wire logic io_hit_o,
    input wire pf_window_t pf_window_o,
    input wire io_window_t io_window_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic [7:0] idx;
    logic done;
    logic known;
    assign idx = avs_address_i[9:2];
    assign done = !avs_waitrequest_o;
    assign known = idx inside {8'h1c, 8'h1d, 8'h24, 8'h26, 8'h28, 8'h2c,
        8'h30, 8'h32, 8'h34, 8'h38, 8'h3c, 8'h50};
    property p_wait_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> done;
    endproperty
    a_wait_answer: assert property (p_wait_answer)
        else $error("no answer one cycle after request");
    property p_wait_one;
        done |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low longer than one cycle");
    property p_response;
        done && (avs_read_i || avs_write_i) |-> avs_response_o ==
            (known ? `RESP_OKAY : `RESP_SLVERR) &&
            (known || avs_write_i || avs_readdata_o == 32'h0);
    endproperty
    a_response: assert property (p_response)
        else $error("wrong response or unmapped read data");
    property p_rom_zero;
        done && avs_read_i && idx == `IDX_OPTION_ROM |->
            avs_readdata_o == 32'h0;
    endproperty
    a_rom_zero: assert property (p_rom_zero)
        else $error("option rom base read not zero");
    property p_limit_mirror;
        done && avs_read_i && idx == `IDX_PF_LIMIT_LOW |->
            avs_readdata_o[3:0] == {3'h0, pf_window_o.wide};
    endproperty
    a_limit_mirror: assert property (p_limit_mirror)
        else $error("limit bit 0 does not mirror capability");
    property p_low_bits;
        $past(rstn_i) |-> pf_window_o.lowest[19:0] == `PF_LOW_ZERO &&
            pf_window_o.highest[19:0] == `PF_LOW_ONES &&
            io_window_o.lowest[11:0] == `IO_LOW_ZERO &&
            io_window_o.highest[11:0] == `IO_LOW_ONES;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("implied low bound bits wrong");
    property p_pf_narrow;
        !pf_window_o.wide |-> pf_window_o.lowest[63:32] == 32'h0 &&
            pf_window_o.highest[63:32] == 32'h0;
    endproperty
    a_pf_narrow: assert property (p_pf_narrow)
        else $error("narrow prefetch window keeps upper half");
    property p_io_narrow;
        !io_window_o.wide |-> io_window_o.lowest[31:16] == 16'h0 &&
            io_window_o.highest[31:16] == 16'h0;
    endproperty
    a_io_narrow: assert property (p_io_narrow)
        else $error("narrow io window keeps upper half");
    // hit flop and window struct load from the same bounds at one edge
    property p_pf_hit;
        $past(rstn_i) |-> pf_hit_o ==
            ($past(pf_addr_i) >= pf_window_o.lowest &&
            $past(pf_addr_i) <= pf_window_o.highest);
    endproperty
    a_pf_hit: assert property (p_pf_hit)
        else $error("prefetch hit disagrees with bounds");
    property p_io_hit;
        $past(rstn_i) |-> io_hit_o ==
            ($past(io_addr_i) >= io_window_o.lowest &&
            $past(io_addr_i) <= io_window_o.highest);
    endproperty
    a_io_hit: assert property (p_io_hit)
        else $error("io hit disagrees with bounds");
    c_read: cover property (done && avs_read_i);
    c_pf_hit: cover property (pf_hit_o);
    c_io_hit: cover property (io_hit_o && !io_window_o.wide);
endmodule
bind bridge_window_upper_regs bridge_window_upper_regs_checker checker_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pf_addr_i(pf_addr_i),
    .io_addr_i(io_addr_i), .pf_hit_o(pf_hit_o), .io_hit_o(io_hit_o),
    .pf_window_o(pf_window_o), .io_window_o(io_window_o));

// File: bridge_window_upper_regs_bench.sv
// bridge_window_upper_regs_bench: register and decode tests over avalon.
// assumes the checker is bound in and one wait state per access.
`timescale 1ns/100ps
`include "bridge_window_upper_regs.svh"
module bridge_window_upper_regs_bench
    import bridge_window_pkg::*;
;
    logic sys_clk_i, rstn_i, avs_read_i, avs_write_i;
    logic avs_waitrequest_o, pf_hit_o, io_hit_o;
    logic [9:0] avs_address_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, io_addr_i, q;
    logic [1:0] avs_response_o, r;
    logic [63:0] pf_addr_i;
    pf_window_t pf_window_o;
    io_window_t io_window_o;
    int failures, tests_run;
    // {index, value} after reset
    logic [39:0] rst_tab [12] = '{40'h26_00000001, 40'h28_ffffffff,
        40'h2c_00000000, 40'h30_0000ffff, 40'h32_00000000, 40'h34_00000040,
        40'h38_00000000, 40'h3c_00000000, 40'h24_0000fff1, 40'h1c_000000f1,
        40'h1d_00000001, 40'h50_00000000};
    // {index, lanes, write data, read back}
    logic [75:0] wr_tab [12] = '{76'h28_f_12345678_12345678,
        76'h28_1_ffffffff_123456ff, 76'h2c_f_9abcdef0_9abcdef0,
        76'h30_f_a5a50001_00000001, 76'h32_f_ffff0002_00000002,
        76'h26_f_ffffabc0_0000abc1, 76'h34_f_00000080_00000040,
        76'h38_f_ffffffff_00000000, 76'h3c_f_000001c3_000000c3,
        76'h24_f_00000100_00000101, 76'h1c_f_00000020_00000021,
        76'h1d_f_00000050_00000051};

    bridge_window_upper_regs bridge_window_upper_regs_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pf_addr_i(pf_addr_i), .io_addr_i(io_addr_i), .pf_hit_o(pf_hit_o),
        .io_hit_o(io_hit_o), .pf_window_o(pf_window_o),
        .io_window_o(io_window_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // holds the request until waitrequest is seen low, then idles one cycle
    // so that back to back calls never drive a strobe twice in one step
    task automatic xfer(input logic w, input logic [7:0] idx,
            input logic [31:0] d, input logic [3:0] be);
        int n;
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            failures++;
            $display("FAIL waitrequest expected 0 seen %b", avs_waitrequest_o);
            report_and_stop();
        end
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
            input logic [3:0] be = 4'hf);
        xfer(1'b1, idx, d, be);
        chk("write response", `RESP_OKAY, r);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
            input logic [1:0] rsp = `RESP_OKAY);
        xfer(1'b0, idx, 32'h0, 4'hf);
        chk($sformatf("read %h", idx), exp, q);
        chk("read response", rsp, r);
    endtask

    task automatic hit(input logic [63:0] pa, input logic [31:0] ia,
            input logic ep, input logic ei);
        pf_addr_i <= pa;
        io_addr_i <= ia;
        repeat (3) @(posedge sys_clk_i);
        chk("pf hit", ep, pf_hit_o);
        chk("io hit", ei, io_hit_o);
    endtask

    initial begin
        failures = 0;
        tests_run = 0;
        rstn_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 10'h0;
        avs_byteenable_i = 4'h0;
        avs_writedata_i = 32'h0;
        pf_addr_i = 64'h0;
        io_addr_i = 32'h0;
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        foreach (rst_tab[i]) begin
            rd(rst_tab[i][39:32], rst_tab[i][31:0]);
        end
        foreach (wr_tab[i]) begin
            wr(wr_tab[i][75:68], wr_tab[i][63:32], wr_tab[i][67:64]);
            rd(wr_tab[i][75:68], wr_tab[i][31:0]);
        end
        repeat (2) @(posedge sys_clk_i);
        chk("pf low", 64'h123456ff_01000000, pf_window_o.lowest);
        chk("pf high", 64'h9abcdef0_abcfffff, pf_window_o.highest);
        hit(64'h123456ff_01000000, 32'h00012000, 1'b1, 1'b1);
        hit(64'h123456ff_00ffffff, 32'h00011fff, 1'b0, 1'b0);
        hit(64'h9abcdef0_abcfffff, 32'h00025fff, 1'b1, 1'b1);
        hit(64'h9abcdef0_abd00000, 32'h00026000, 1'b0, 1'b0);
        wr(8'h50, 32'h1);
        wr(8'h34, 32'h80);
        rd(8'h34, 32'h80);
        wr(8'h24, 32'h100);
        rd(8'h24, 32'h100);
        rd(8'h26, 32'habc0);
        wr(8'h28, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h2c, 32'h0);
        wr(8'h1c, 32'h20);
        wr(8'h32, 32'h0);
        rd(8'h30, 32'h0);
        rd(8'h32, 32'h0);
        wr(8'h3c, 32'h5a);
        hit(64'h00000000_01000000, 32'h00002000, 1'b1, 1'b1);
        hit(64'h123456ff_01000000, 32'h00012000, 1'b0, 1'b0);
        wr(8'h24, 32'h101);
        wr(8'h1c, 32'h21);
        rd(8'h28, 32'h123456ff);
        rd(8'h32, 32'h2);
        xfer(1'b1, 8'h3f, 32'hffffffff, 4'hf);
        chk("unmapped write response", `RESP_SLVERR, r);
        rd(8'h3f, 32'h0, `RESP_SLVERR);
        rstn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(8'h34, 32'h40);
        rd(8'h28, 32'hffffffff);
        rd(8'h3c, 32'h0);
        report_and_stop();
    end
endmodule
